/* verilog/pmc_defines.svh */
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH
// ----------------------------------------
// reset cause encodings
// ----------------------------------------
`define PMC_CAUSE_POR      2'h0
`define PMC_CAUSE_PIN      2'h1
`define PMC_CAUSE_SHDN     2'h2
// ----------------------------------------
// mode request encodings
// ----------------------------------------
`define PMC_REQ_IDLE       2'h1
`define PMC_REQ_STANDBY    2'h2
`define PMC_REQ_SHUTDOWN   2'h3
// ----------------------------------------
// timing
// ----------------------------------------
`define PMC_SETTLE_NS      40
`define PMC_CLK_NS         10
`define PMC_SETTLE_CYC     ((`PMC_SETTLE_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
`endif

/* verilog/pmc_pkg.sv */
`default_nettype none
package pmc_pkg;
    // ----------------------------------------
    // power mode states
    // ----------------------------------------
    typedef enum logic [2:0] {
        PMC_ACTIVE   = 3'b000,
        PMC_TO_IDLE  = 3'b001,
        PMC_IDLE     = 3'b010,
        PMC_TO_STBY  = 3'b011,
        PMC_STANDBY  = 3'b100,
        PMC_TO_SHDN  = 3'b101,
        PMC_SHUTDOWN = 3'b110,
        PMC_WAKE     = 3'b111
    } pmc_state_t;
endpackage
`default_nettype wire

/* verilog/pmc_wake_if.sv */
`default_nettype none
interface pmc_wake_if #(parameter int NPIN = 8);
    logic [NPIN-1:0] pin;
    logic [NPIN-1:0] mask;
    logic            arm;
    logic            hit;
    modport det (input pin, input mask, input arm, output hit);
    modport ctl (output pin, output mask, output arm, input hit);
endinterface
`default_nettype wire

/* verilog/pmc_pin_wake.sv */
`default_nettype none
module pmc_pin_wake #(
    parameter int NPIN = 8
) (
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    // wake pins
    pmc_wake_if.det   wk
);
    // ----------------------------------------
    // per-pin level-change detect
    // ----------------------------------------
    logic [NPIN-1:0] ref_reg;
    logic [NPIN-1:0] chg;
    logic            hit_reg;

    // reference is taken while not armed, so any change on a masked-in pin after arm counts
    genvar g;
    generate
        for (g = 0; g < NPIN; g = g + 1) begin : g_pin
            assign chg[g] = wk.mask[g] & (wk.pin[g] ^ ref_reg[g]);
        end
    endgenerate

    // snapshot follows the pins until armed
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ref_reg <= '0;
            hit_reg <= 1'b0;
        end else begin
            if (!wk.arm) begin
                ref_reg <= wk.pin;
            end
            hit_reg <= wk.arm & (|chg);
        end
    end

    assign wk.hit = hit_reg;
endmodule // pmc_pin_wake
`default_nettype wire

/* verilog/pmc_power_mode_controller.sv */
`include "pmc_defines.svh"
`default_nettype none
module pmc_power_mode_controller #(
    parameter int NPIN = 8
) (
    // clock and reset
    input  wire logic            sys_clk_i,
    input  wire logic            rst_i,
    // reset sources
    input  wire logic            por_i,
    input  wire logic            reset_pin_i,
    // cpu request
    input  wire logic            mode_req_i,
    input  wire logic [1:0]      mode_sel_i,
    // wake sources
    input  wire logic            irq_i,
    input  wire logic            ext_wake_i,
    input  wire logic            rtc_wake_i,
    input  wire logic            sensor_wake_i,
    input  wire logic [NPIN-1:0] io_pin_i,
    input  wire logic [NPIN-1:0] shdn_wake_en_i,
    // domain controls
    output logic                 cpu_clk_en_o,
    output logic                 periph_clk_en_o,
    output logic                 always_on_domain_pwr_o,
    output logic                 core_pwr_o,
    output logic                 sram_retain_o,
    output logic                 reg_retain_full_o,
    output logic                 reg_retain_part_o,
    output logic                 io_latch_o,
    output logic [NPIN-1:0]      io_latched_o,
    output logic                 state_clear_o,
    output logic [2:0]           mode_o,
    // status
    output logic [1:0]           reset_cause_o
);
    // ----------------------------------------
    // state and wake capture
    // ----------------------------------------
    localparam logic [2:0] SETTLE = 3'(`PMC_SETTLE_CYC);

    pmc_pkg::pmc_state_t state_reg, state_next;
    logic [2:0]          cnt_reg;
    logic                wake_pend_reg;
    logic                irq_pend_reg;
    logic [1:0]          cause_reg;
    logic [NPIN-1:0]     io_hold_reg;
    logic                shdn_hit;
    logic                aon_wake;
    logic                settled;

    pmc_wake_if #(.NPIN(NPIN)) wk ();
    assign wk.pin  = io_pin_i;
    assign wk.mask = shdn_wake_en_i;
    assign wk.arm  = (state_reg == pmc_pkg::PMC_SHUTDOWN);

    pmc_pin_wake #(.NPIN(NPIN)) u_wake (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .wk        (wk)
    );
    assign shdn_hit = wk.hit;

    // only always-on sources may end standby
    assign aon_wake = ext_wake_i | rtc_wake_i | sensor_wake_i;
    assign settled  = (cnt_reg == SETTLE);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            pmc_pkg::PMC_ACTIVE: begin
                if (mode_req_i) begin
                    case (mode_sel_i)
                        `PMC_REQ_IDLE:
                            state_next = pmc_pkg::PMC_TO_IDLE;
                        `PMC_REQ_STANDBY:
                            state_next = pmc_pkg::PMC_TO_STBY;
                        `PMC_REQ_SHUTDOWN:
                            state_next = pmc_pkg::PMC_TO_SHDN;
                        default:
                            state_next = pmc_pkg::PMC_ACTIVE;
                    endcase
                end
            end
            pmc_pkg::PMC_TO_IDLE: begin
                if (settled) begin
                    state_next = pmc_pkg::PMC_IDLE;
                end
            end
            pmc_pkg::PMC_IDLE: begin
                if (irq_i | irq_pend_reg) begin
                    state_next = pmc_pkg::PMC_WAKE;
                end
            end
            pmc_pkg::PMC_TO_STBY: begin
                if (settled) begin
                    state_next = pmc_pkg::PMC_STANDBY;
                end
            end
            pmc_pkg::PMC_STANDBY: begin
                if (aon_wake | wake_pend_reg) begin
                    state_next = pmc_pkg::PMC_WAKE;
                end
            end
            pmc_pkg::PMC_TO_SHDN: begin
                if (settled) begin
                    state_next = pmc_pkg::PMC_SHUTDOWN;
                end
            end
            pmc_pkg::PMC_SHUTDOWN: begin
                // wake from shutdown goes straight to active, skipping the wake settle
                if (shdn_hit) begin
                    state_next = pmc_pkg::PMC_ACTIVE;
                end
            end
            pmc_pkg::PMC_WAKE: begin
                if (settled) begin
                    state_next = pmc_pkg::PMC_ACTIVE;
                end
            end
            default: state_next = pmc_pkg::PMC_ACTIVE;
        endcase
    end

    // ----------------------------------------
    // state register and settle counter
    // ----------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i | por_i | reset_pin_i) begin
            state_reg <= pmc_pkg::PMC_ACTIVE;
            cnt_reg   <= 3'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= (state_next != state_reg) ? 3'h0 :
                         (settled ? cnt_reg : cnt_reg + 3'h1);
        end
    end

    // ----------------------------------------
    // wakes seen mid-transition are held
    // ----------------------------------------
    // only the idle and standby entry ramps pend; a wake still high while already waking
    // would otherwise linger and cut the next low-power visit short
    always_ff @(posedge sys_clk_i) begin
        if (rst_i | por_i | reset_pin_i) begin
            wake_pend_reg <= 1'b0;
            irq_pend_reg  <= 1'b0;
        end else begin
            if ((state_reg == pmc_pkg::PMC_TO_STBY) & aon_wake) begin
                wake_pend_reg <= 1'b1;
            end else if (state_reg == pmc_pkg::PMC_STANDBY) begin
                wake_pend_reg <= 1'b0;
            end
            if ((state_reg == pmc_pkg::PMC_TO_IDLE) & irq_i) begin
                irq_pend_reg <= 1'b1;
            end else if (state_reg == pmc_pkg::PMC_IDLE) begin
                irq_pend_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // reset cause
    // ----------------------------------------
    // por outranks the pin, the pin outranks a shutdown wake
    always_ff @(posedge sys_clk_i) begin
        if (rst_i | por_i) begin
            cause_reg <= `PMC_CAUSE_POR;
        end else if (reset_pin_i) begin
            cause_reg <= `PMC_CAUSE_PIN;
        end else if (wk.arm & shdn_hit) begin
            cause_reg <= `PMC_CAUSE_SHDN;
        end
    end

    // ----------------------------------------
    // io hold: frozen from standby/shutdown entry
    // ----------------------------------------
    logic hold_now;
    assign hold_now = (state_next == pmc_pkg::PMC_STANDBY) |
                      (state_next == pmc_pkg::PMC_SHUTDOWN);

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            io_hold_reg <= '0;
            io_latch_o  <= 1'b0;
        end else begin
            if (!io_latch_o) begin
                io_hold_reg <= io_pin_i;
            end
            io_latch_o <= hold_now;
        end
    end
    assign io_latched_o = io_hold_reg;

    // ----------------------------------------
    // domain controls, registered from state
    // ----------------------------------------
    logic act_n, idl_n, stb_n, shd_n;
    assign act_n = (state_next == pmc_pkg::PMC_ACTIVE) |
                   (state_next == pmc_pkg::PMC_TO_IDLE) |
                   (state_next == pmc_pkg::PMC_TO_STBY) |
                   (state_next == pmc_pkg::PMC_TO_SHDN) |
                   (state_next == pmc_pkg::PMC_WAKE);
    assign idl_n = (state_next == pmc_pkg::PMC_IDLE);
    assign stb_n = (state_next == pmc_pkg::PMC_STANDBY);
    assign shd_n = (state_next == pmc_pkg::PMC_SHUTDOWN);

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cpu_clk_en_o           <= 1'b0;
            periph_clk_en_o        <= 1'b0;
            always_on_domain_pwr_o <= 1'b1;
            core_pwr_o             <= 1'b0;
            sram_retain_o          <= 1'b0;
            reg_retain_full_o      <= 1'b0;
            reg_retain_part_o      <= 1'b0;
            state_clear_o          <= 1'b1;
            mode_o                 <= 3'h0;
        end else begin
            cpu_clk_en_o           <= act_n;
            periph_clk_en_o        <= act_n | idl_n;
            always_on_domain_pwr_o <= !shd_n;
            core_pwr_o             <= act_n | idl_n;
            sram_retain_o          <= !shd_n;
            reg_retain_full_o      <= act_n | idl_n;
            reg_retain_part_o      <= stb_n;
            state_clear_o          <= shd_n;
            mode_o                 <= state_next;
        end
    end
    assign reset_cause_o = cause_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_idle_clk;
        @(posedge sys_clk_i) disable iff (rst_i)
        state_reg == pmc_pkg::PMC_IDLE |-> !cpu_clk_en_o && periph_clk_en_o;
    endproperty
    a_idle_clk: assert property (p_idle_clk)
        else $error("cpu clock running in idle");

    sequence s_idle_irq;
        state_reg == pmc_pkg::PMC_IDLE && irq_i;
    endsequence
    property p_idle_wake;
        @(posedge sys_clk_i) disable iff (rst_i | por_i | reset_pin_i)
        s_idle_irq |=> state_reg == pmc_pkg::PMC_WAKE
                       ##[1:8] state_reg == pmc_pkg::PMC_ACTIVE;
    endproperty
    a_idle_wake: assert property (p_idle_wake)
        else $error("interrupt did not end idle");

    property p_stby_stay;
        @(posedge sys_clk_i) disable iff (rst_i | por_i | reset_pin_i)
        state_reg == pmc_pkg::PMC_STANDBY && !aon_wake && !wake_pend_reg
        |=> state_reg == pmc_pkg::PMC_STANDBY;
    endproperty
    a_stby_stay: assert property (p_stby_stay)
        else $error("standby left without wake");

    property p_stby_ret;
        @(posedge sys_clk_i) disable iff (rst_i)
        state_reg == pmc_pkg::PMC_STANDBY
        |-> reg_retain_part_o && sram_retain_o;
    endproperty
    a_stby_ret: assert property (p_stby_ret)
        else $error("standby retention lost");

    property p_io_latch;
        @(posedge sys_clk_i) disable iff (rst_i)
        $past(state_reg) == pmc_pkg::PMC_STANDBY && io_latch_o
        |-> $stable(io_latched_o);
    endproperty
    a_io_latch: assert property (p_io_latch)
        else $error("io moved in standby");

    property p_shdn_off;
        @(posedge sys_clk_i) disable iff (rst_i)
        $past(state_reg) == pmc_pkg::PMC_SHUTDOWN && state_reg ==
        pmc_pkg::PMC_SHUTDOWN |-> !always_on_domain_pwr_o && !sram_retain_o
                                  && state_clear_o;
    endproperty
    a_shdn_off: assert property (p_shdn_off)
        else $error("domain powered in shutdown");

    property p_shdn_cause;
        @(posedge sys_clk_i) disable iff (rst_i | por_i | reset_pin_i)
        state_reg == pmc_pkg::PMC_SHUTDOWN && shdn_hit
        |=> reset_cause_o == `PMC_CAUSE_SHDN
            && state_reg == pmc_pkg::PMC_ACTIVE;
    endproperty
    a_shdn_cause: assert property (p_shdn_cause)
        else $error("shutdown wake not recorded");

    property p_req_only;
        @(posedge sys_clk_i) disable iff (rst_i | por_i | reset_pin_i)
        state_reg == pmc_pkg::PMC_ACTIVE && !mode_req_i
        |=> state_reg == pmc_pkg::PMC_ACTIVE;
    endproperty
    a_req_only: assert property (p_req_only)
        else $error("mode left without request");
endmodule // pmc_power_mode_controller
`default_nettype wire

/* verif/pmc_wake_src.sv */
`default_nettype none
// ----------------------------------------
// wake source model: rtc, sensor, ext, irq
// ----------------------------------------
module pmc_wake_src #(
    parameter int HOLD = 2
) (
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    // fire one source per bit: 0 irq, 1 ext, 2 rtc, 3 sensor
    input  wire logic [3:0] go_i,
    // wake lines
    output logic            irq_o,
    output logic            ext_wake_o,
    output logic            rtc_wake_o,
    output logic            sensor_wake_o
);
    logic [3:0] cnt_reg [4];

    // each source holds its level a few cycles, then drops, so a
    // design that only samples on the first edge still sees it
    always_ff @(posedge sys_clk_i) begin
        for (int i = 0; i < 4; i++) begin
            if (rst_i) begin
                cnt_reg[i] <= 4'h0;
            end else if (go_i[i]) begin
                cnt_reg[i] <= 4'(HOLD);
            end else if (cnt_reg[i] != 4'h0) begin
                cnt_reg[i] <= cnt_reg[i] - 4'h1;
            end
        end
    end

    // levels seen by the controller
    assign irq_o         = (cnt_reg[0] != 4'h0);
    assign ext_wake_o    = (cnt_reg[1] != 4'h0);
    assign rtc_wake_o    = (cnt_reg[2] != 4'h0);
    assign sensor_wake_o = (cnt_reg[3] != 4'h0);
endmodule // pmc_wake_src
`default_nettype wire

/* verif/testbench.sv */
`include "pmc_defines.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic       sys_clk_i, rst_i, por_i, reset_pin_i, mode_req_i;
    logic [1:0] mode_sel_i, reset_cause_o;
    logic [3:0] go;
    logic       irq, ext_w, rtc_w, sen_w;
    logic [7:0] io_pin_i, shdn_wake_en_i, io_latched_o;
    logic       cpu_clk_en_o, periph_clk_en_o, aon_o, core_pwr_o;
    logic       sram_retain_o, reg_full_o, reg_part_o, io_latch_o;
    logic       state_clear_o;
    logic [2:0] mode_o;
    int         n_errors, total_checks;

    pmc_power_mode_controller #(.NPIN(8)) dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .por_i(por_i),
        .reset_pin_i(reset_pin_i), .mode_req_i(mode_req_i),
        .mode_sel_i(mode_sel_i), .irq_i(irq), .ext_wake_i(ext_w),
        .rtc_wake_i(rtc_w), .sensor_wake_i(sen_w), .io_pin_i(io_pin_i),
        .shdn_wake_en_i(shdn_wake_en_i), .cpu_clk_en_o(cpu_clk_en_o),
        .periph_clk_en_o(periph_clk_en_o),
        .always_on_domain_pwr_o(aon_o), .core_pwr_o(core_pwr_o),
        .sram_retain_o(sram_retain_o), .reg_retain_full_o(reg_full_o),
        .reg_retain_part_o(reg_part_o), .io_latch_o(io_latch_o),
        .io_latched_o(io_latched_o), .state_clear_o(state_clear_o),
        .mode_o(mode_o), .reset_cause_o(reset_cause_o));

    pmc_wake_src #(.HOLD(2)) u_wake (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .go_i(go), .irq_o(irq),
        .ext_wake_o(ext_w), .rtc_wake_o(rtc_w), .sensor_wake_o(sen_w));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic report_and_stop();
        if (n_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // one-cycle request pulse, taken only while active
    task automatic request(input logic [1:0] sel);
        @(posedge sys_clk_i);
        mode_req_i <= 1'b1;
        mode_sel_i <= sel;
        @(posedge sys_clk_i);
        mode_req_i <= 1'b0;
        mode_sel_i <= 2'h0;
    endtask

    task automatic fire(input int k);
        @(posedge sys_clk_i);
        go <= 4'(1 << k);
        @(posedge sys_clk_i);
        go <= 4'h0;
    endtask

    task automatic idle_cycles(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    // bounded wait for a mode code; running out ends the run
    task automatic wait_mode(input logic [2:0] m);
        int i;
        for (i = 0; i < 40; i++) begin
            @(posedge sys_clk_i);
            #1;
            if (mode_o === m) break;
        end
        if (i == 40) begin
            n_errors++;
            $display("wrong value mode_o expected %0h seen %0h", m, mode_o);
            report_and_stop();
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_idle();
        request(`PMC_REQ_IDLE);
        wait_mode(pmc_pkg::PMC_IDLE);
        check("cpu_clk_en", cpu_clk_en_o, 8'h00);
        check("periph_clk_en", periph_clk_en_o, 8'h01);
        check("reg_full", reg_full_o, 8'h01);
        check("sram", sram_retain_o, 8'h01);
        request(`PMC_REQ_SHUTDOWN);
        idle_cycles(8);
        check("mode_refused", mode_o, 8'(pmc_pkg::PMC_IDLE));
        fire(0);
        wait_mode(pmc_pkg::PMC_ACTIVE);
        check("cpu_clk_back", cpu_clk_en_o, 8'h01);
    endtask

    task automatic t_standby();
        for (int k = 1; k < 4; k++) begin
            io_pin_i <= 8'(8'hA0 + k);
            request(`PMC_REQ_STANDBY);
            wait_mode(pmc_pkg::PMC_STANDBY);
            io_pin_i <= 8'h3C;
            fire(0);
            idle_cycles(10);
            check("stby_mode", mode_o, 8'(pmc_pkg::PMC_STANDBY));
            check("stby_aon", aon_o, 8'h01);
            check("stby_core", core_pwr_o, 8'h00);
            check("stby_latch", io_latch_o, 8'h01);
            check("stby_io", io_latched_o, 8'(8'hA0 + k));
            check("stby_part", reg_part_o, 8'h01);
            check("stby_clear", state_clear_o, 8'h00);
            check("stby_sram", sram_retain_o, 8'h01);
            fire(k);
            wait_mode(pmc_pkg::PMC_ACTIVE);
            check("resume_full", reg_full_o, 8'h01);
            check("resume_clear", state_clear_o, 8'h00);
        end
    endtask

    task automatic t_shutdown();
        io_pin_i       <= 8'h5A;
        shdn_wake_en_i <= 8'h01;
        request(`PMC_REQ_SHUTDOWN);
        wait_mode(pmc_pkg::PMC_SHUTDOWN);
        check("shdn_aon", aon_o, 8'h00);
        check("shdn_io", io_latched_o, 8'h5A);
        check("shdn_latch", io_latch_o, 8'h01);
        check("shdn_clear", state_clear_o, 8'h01);
        check("shdn_regs", {reg_full_o, reg_part_o}, 8'h00);
        check("shdn_sram", sram_retain_o, 8'h00);
        io_pin_i <= 8'hDA;
        fire(2);
        idle_cycles(8);
        check("shdn_hold", mode_o, 8'(pmc_pkg::PMC_SHUTDOWN));
        check("shdn_io_kept", io_latched_o, 8'h5A);
        io_pin_i <= 8'hDB;
        wait_mode(pmc_pkg::PMC_ACTIVE);
        check("cause_shdn", reset_cause_o, 8'(`PMC_CAUSE_SHDN));
        shdn_wake_en_i <= 8'h00;
    endtask

    task automatic t_causes();
        @(posedge sys_clk_i);
        reset_pin_i <= 1'b1;
        @(posedge sys_clk_i);
        reset_pin_i <= 1'b0;
        idle_cycles(3);
        check("cause_pin", reset_cause_o, 8'(`PMC_CAUSE_PIN));
        check("pin_mode", mode_o, 8'(pmc_pkg::PMC_ACTIVE));
        @(posedge sys_clk_i);
        por_i <= 1'b1;
        @(posedge sys_clk_i);
        por_i <= 1'b0;
        idle_cycles(3);
        check("cause_por", reset_cause_o, 8'(`PMC_CAUSE_POR));
    endtask

    task automatic t_requests();
        request(2'h0);
        idle_cycles(8);
        check("sel0_ignored", mode_o, 8'(pmc_pkg::PMC_ACTIVE));
        // irq lands while still heading into idle and must be kept
        request(`PMC_REQ_IDLE);
        fire(0);
        wait_mode(pmc_pkg::PMC_ACTIVE);
    endtask

    // ----------------------------------------
    // clock, reset, sequence, watchdog
    // ----------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    initial begin
        n_errors = 0;
        total_checks = 0;
        {rst_i, por_i, reset_pin_i, mode_req_i} = 4'h8;
        mode_sel_i = 2'h0;
        go = 4'h0;
        io_pin_i = 8'h00;
        shdn_wake_en_i = 8'h00;
        idle_cycles(4);
        check("rst_aon", aon_o, 8'h01);
        check("rst_clear", state_clear_o, 8'h01);
        check("rst_sram", sram_retain_o, 8'h00);
        check("rst_cause", reset_cause_o, 8'(`PMC_CAUSE_POR));
        rst_i <= 1'b0;
        idle_cycles(2);
        check("act_full", reg_full_o, 8'h01);
        check("act_sram", sram_retain_o, 8'h01);
        t_idle();
        t_standby();
        t_shutdown();
        t_causes();
        t_requests();
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        n_errors++;
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
